// file: verilog/mrb_pkg.sv
// Purpose: Shared constants and types for the mode register block
// Assumes: Single clock, synchronous reset
// Notes: Field positions follow the mode register bit layout
package mrb_pkg;
	// ***************************
	// Widths
	// ***************************
	localparam int DQ_W = 8; // Data lane width
	localparam int COL_W = 3; // Low column bits in a burst
	localparam int MR0_W = 13; // Stored bits of register zero
	localparam int MR1_W = 18; // Stored bits of register one
	localparam int SEL_W = 3; // Bank select on a set command
	localparam int LAT_W = 5; // Latency counters
	localparam int LOCK_W = 10; // Lock counter
	// ***************************
	// Register select and fields
	// ***************************
	localparam logic [SEL_W-1:0] SEL_MR0 = 3'h0;
	localparam logic [SEL_W-1:0] SEL_MR1 = 3'h1;
	localparam int BL_HI = 1; // Burst length field
	localparam int BL_LO = 0;
	localparam int CL_LOW_B = 2; // Latency extension bit
	localparam int BT_B = 3; // Burst type
	localparam int CL_HI = 6; // Latency field
	localparam int CL_LO = 4;
	localparam int DLLRST_B = 8; // Self-clearing DLL reset
	localparam int WR_HI = 11; // Write recovery field
	localparam int WR_LO = 9;
	localparam int PD_B = 12; // Power-down DLL option
	localparam int DLL_DIS_B = 0; // One disables the DLL
	localparam int WLVL_B = 7; // Write leveling
	localparam int QOFF_B = 12; // Output disable
	localparam int NIB_B = 2; // Nibble select column bit
	localparam logic [MR0_W-1:0] MR0_RST = 13'h0000;
	localparam logic [MR1_W-1:0] MR1_RST = 18'h00000;
	localparam logic [1:0] BL_OTF = 2'h1;
	localparam logic [1:0] BL_FIX4 = 2'h2;
	// ***************************
	// Latency and timing
	// ***************************
	localparam logic [LAT_W-1:0] CL_BASE_LO = 5'h04;
	localparam logic [LAT_W-1:0] CL_BASE_HI = 5'h0C;
	localparam logic [LAT_W-1:0] CL_DLL_OFF = 5'h06;
	localparam logic [LAT_W-1:0] LAT_LEAD = 5'h02; // Issue plus output stage
	localparam int DLL_LOCK_CYCLES = 512;
	localparam logic [LOCK_W-1:0] DLL_LOCK_CNT = LOCK_W'(DLL_LOCK_CYCLES);
	// Write recovery per code, code zero is sixteen
	localparam logic [4:0] WR_TBL [8] = '{5'h10, 5'h05, 5'h06, 5'h07,
		5'h08, 5'h0A, 5'h0C, 5'h0E};
	localparam logic [COL_W-1:0] CHOP_BEAT = 3'h4; // First hidden beat
	localparam logic [COL_W-1:0] LAST_BEAT = 3'h7;
	localparam logic [COL_W:0] BEATS_FULL = 4'h8;
	localparam logic [COL_W:0] BEATS_CHOP = 4'h4;
	// ***************************
	// Types
	// ***************************
	typedef enum {RD_IDLE, RD_WAIT, RD_BURST} mrb_rd_st_t;
	typedef struct packed {
		logic [SEL_W-1:0] sel; // Target register
		logic [MR1_W-1:0] val; // Address bits
	} mrb_mrs_t;
	typedef struct packed {
		logic wr; // One for write
		logic a12; // Chop select on the fly
		logic [COL_W-1:0] col; // Starting column
	} mrb_cmd_t;
	typedef struct packed {
		logic [COL_W-1:0] col;
		logic [DQ_W-1:0] dat;
	} mrb_wbeat_t;
endpackage

// file: verilog/mrb_fifo.sv
// Purpose: Flop-based FIFO for write beats
// Assumes: DEPTH is a power of two
// Notes: Ready low when full, valid low when empty
module mrb_fifo import mrb_pkg::*; #(
	parameter int W = 11,
	parameter int DEPTH = 16
) (
	input wire logic clk_in,
	input wire logic srst_in,
	input wire logic [W-1:0] in_data_in,
	input wire logic in_valid_in,
	output logic in_ready_out,
	output logic [W-1:0] out_data_out,
	output logic out_valid_out,
	input wire logic out_ready_in
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0] mem_reg [DEPTH]; // Storage
	logic [AW-1:0] wptr_reg; // Write index
	logic [AW-1:0] rptr_reg; // Read index
	logic [AW:0] cnt_reg; // Fill level
	logic push;
	logic pop;
	assign in_ready_out = (cnt_reg != (AW+1)'(DEPTH));
	assign out_valid_out = (cnt_reg != '0);
	assign out_data_out = mem_reg[rptr_reg];
	assign push = in_valid_in && in_ready_out;
	assign pop = out_valid_out && out_ready_in;
	// Storage needs no reset
	always_ff @(posedge clk_in) begin
		if (push) begin
			mem_reg[wptr_reg] <= in_data_in;
		end
	end
	// Pointers and level
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			wptr_reg <= '0;
			rptr_reg <= '0;
			cnt_reg <= '0;
		end else begin
			if (push) begin
				wptr_reg <= wptr_reg + 1'b1;
			end
			if (pop) begin
				rptr_reg <= rptr_reg + 1'b1;
			end
			if (push && !pop) begin
				cnt_reg <= cnt_reg + 1'b1;
			end else if (pop && !push) begin
				cnt_reg <= cnt_reg - 1'b1;
			end
		end
	end
endmodule

// file: verilog/mrb_mode_regs.sv
// Purpose: Mode registers zero and one, burst order, DLL control
// Assumes: Commands come from controller logic on clk_in
// Notes: Self refresh and power-down levels arrive from pins
//*******************************
// Mode register block
//*******************************
// What this block and its controller do
// RULE_01 - Burst type bit picks sequential or interleaved
// RULE_02 - Sequential read rotates within nibble, then other
// RULE_03 - Interleaved read column is start XOR beat
// RULE_04 - Chopped read drives four, tri-states four
// RULE_05 - Chopped write: bit two picks nibble, ascending
// RULE_06 - Eight-beat write always ascending zero to seven
// RULE_07 - Chop and full bursts start together
// RULE_08 - DLL reset bit starts reset, self-clears
// RULE_09 - Controller waits 512 clocks before reads
// RULE_10 - Write recovery field selects 5 to 16
// RULE_11 - Controller rounds write recovery cycles up
// RULE_12 - Option zero stops DLL in power-down
// RULE_13 - Option one keeps DLL running in power-down
// RULE_14 - Latency field selects whole clocks 5 to 14
// RULE_15 - First read data at edge n plus latency
// RULE_16 - Controller loads register one when idle
// RULE_17 - Register one holds until rewrite or reset
// RULE_18 - Controller zeroes reserved register one bits
// RULE_19 - Leveling termination set depends on output-off
// RULE_20 - Bit zero enables DLL, then reset
// RULE_21 - Self refresh stops and restarts enabled DLL
// RULE_22 - DLL off: no termination, latency six
// RULE_23 - On-the-fly length: A12 low means chop
// RULE_24 - Controller zeroes reserved register zero bits
module mrb_mode_regs import mrb_pkg::*; #(
	parameter int FIFO_DEPTH = 16
) (
	input wire logic clk_in,
	input wire logic srst_in,
	input wire logic mrs_valid_in,
	input wire mrb_mrs_t mrs_in,
	input wire logic cmd_valid_in,
	input wire mrb_cmd_t cmd_in,
	output logic cmd_ready_out,
	input wire logic sref_in,
	input wire logic pdn_in,
	output logic rd_req_out,
	output logic [COL_W-1:0] rd_col_out,
	input wire logic [DQ_W-1:0] array_rdata_in,
	output logic [DQ_W-1:0] dq_out,
	output logic dq_oe_n_out,
	output logic dqs_out,
	input wire logic wbeat_valid_in,
	input wire logic [DQ_W-1:0] dq_in,
	output logic wbeat_ready_out,
	output logic array_wr_valid_out,
	output mrb_wbeat_t array_wr_out,
	input wire logic array_wr_ready_in,
	output logic [LAT_W-1:0] read_latency_out,
	output logic [4:0] wr_recovery_out,
	output logic dll_on_out,
	output logic dll_locked_out,
	output logic slow_pd_exit_out,
	output logic odt_allow_out,
	output logic rtt_all_out,
	output logic rtt_wr_only_out,
	output logic [MR0_W-1:0] mode_zero_out,
	output logic [MR1_W-1:0] mode_one_out
);
	//*******************************
	// Pin synchronisers
	//*******************************
	logic [1:0] sync1_reg; // First stage, feeds stage two only
	logic [1:0] sync2_reg; // Bit 1 self refresh, bit 0 power-down
	logic sref_d_reg; // Delayed copy for exit edge
	logic sref_s;
	logic pdn_s;
	// Two flops per pin level
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
			sref_d_reg <= 1'b0;
		end else begin
			sync1_reg <= {sref_in, pdn_in};
			sync2_reg <= sync1_reg;
			sref_d_reg <= sync2_reg[1];
		end
	end
	assign sref_s = sync2_reg[1];
	assign pdn_s = sync2_reg[0];

	//*******************************
	// Mode registers
	//*******************************
	logic [MR0_W-1:0] mr0_reg; // Register zero
	logic [MR1_W-1:0] mr1_reg; // Register one
	logic mr0_wr;
	logic mr1_wr;
	assign mr0_wr = mrs_valid_in && (mrs_in.sel == SEL_MR0);
	assign mr1_wr = mrs_valid_in && (mrs_in.sel == SEL_MR1);
	// Register zero; reserved high bits are dropped
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			mr0_reg <= MR0_RST;
		end else if (mr0_wr) begin
			// A new write wins over the self-clear
			mr0_reg <= mrs_in.val[MR0_W-1:0];
		end else begin
			mr0_reg[DLLRST_B] <= 1'b0; // RULE_08
		end
	end
	// Register one, kept until rewrite or reset
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			mr1_reg <= MR1_RST;
		end else if (mr1_wr) begin
			mr1_reg <= mrs_in.val; // RULE_17
		end
	end
	assign mode_zero_out = mr0_reg;
	assign mode_one_out = mr1_reg;

	//*******************************
	// Mode decodes
	//*******************************
	logic dll_en; // DLL enabled by register one
	logic dll_run; // DLL actually running
	logic chop_now; // Chop for the command on offer
	logic [LAT_W-1:0] cl_raw;
	logic [LAT_W-1:0] cl_eff;
	logic [LAT_W-1:0] cl_field;
	assign dll_en = !mr1_reg[DLL_DIS_B]; // RULE_20
	// Option bit decides DLL in power-down
	assign dll_run = dll_en && !sref_s && !(pdn_s && !mr0_reg[PD_B]); // RULE_12 RULE_13
	assign cl_field = LAT_W'(mr0_reg[CL_HI:CL_LO]);
	// Whole clocks only; extension bit reaches twelve up
	assign cl_raw = mr0_reg[CL_LOW_B] ? CL_BASE_HI + cl_field : CL_BASE_LO + cl_field; // RULE_14
	assign cl_eff = dll_en ? cl_raw : CL_DLL_OFF; // RULE_22
	// Fixed four, or on-the-fly with A12 low
	assign chop_now = (mr0_reg[BL_HI:BL_LO] == BL_FIX4) ||
		((mr0_reg[BL_HI:BL_LO] == BL_OTF) && !cmd_in.a12); // RULE_23
	assign read_latency_out = cl_eff;
	assign wr_recovery_out = WR_TBL[mr0_reg[WR_HI:WR_LO]]; // RULE_10
	assign slow_pd_exit_out = !mr0_reg[PD_B]; // RULE_12
	// No termination with DLL off or in self refresh
	assign odt_allow_out = dll_en && !sref_s; // RULE_22
	assign rtt_all_out = mr1_reg[WLVL_B] && mr1_reg[QOFF_B]; // RULE_19
	assign rtt_wr_only_out = mr1_reg[WLVL_B] && !mr1_reg[QOFF_B]; // RULE_19
	assign dll_on_out = dll_run;

	//*******************************
	// DLL lock tracking
	//*******************************
	logic [LOCK_W-1:0] lock_cnt_reg; // Cycles left to lock
	logic count_en_reg; // Lock count running
	logic dll_rst_go;
	// Register reset, or self refresh exit with DLL enabled
	assign dll_rst_go = (mr0_wr && mrs_in.val[DLLRST_B]) ||
		(sref_d_reg && !sref_s && dll_en); // RULE_08 RULE_21
	// Disabling forces a fresh reset before lock
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			lock_cnt_reg <= DLL_LOCK_CNT;
			count_en_reg <= 1'b0;
		end else if (mr1_wr && mrs_in.val[DLL_DIS_B]) begin
			lock_cnt_reg <= DLL_LOCK_CNT; // RULE_20
			count_en_reg <= 1'b0;
		end else if (dll_rst_go) begin
			lock_cnt_reg <= DLL_LOCK_CNT;
			count_en_reg <= 1'b1;
		end else if (count_en_reg) begin
			if (lock_cnt_reg == '0) begin
				count_en_reg <= 1'b0;
			end else begin
				lock_cnt_reg <= lock_cnt_reg - 1'b1;
			end
		end
	end
	// Advisory only; reads are not refused here
	assign dll_locked_out = dll_run && !count_en_reg && (lock_cnt_reg == '0);

	//*******************************
	// Read burst sequencer
	//*******************************
	mrb_rd_st_t rd_st_reg; // Sequencer state
	logic [LAT_W-1:0] lat_cnt_reg; // Wait before first issue
	logic [LAT_W-1:0] lat_reg; // Latency of this read
	logic [LAT_W-1:0] age_reg; // Cycles since the read
	logic [COL_W-1:0] start_reg; // Starting column
	logic [COL_W-1:0] beat_reg; // Next beat slot
	logic [COL_W-1:0] iss_beat_reg; // Beat slot just issued
	logic [COL_W-1:0] rd_col_reg;
	logic ilv_reg; // Interleaved order
	logic chop_reg; // Four-beat chop
	logic rd_req_reg;
	logic wr_act_reg; // Write burst open
	logic rd_go;
	logic wr_go;
	logic rd_issue;
	logic rd_drv;
	// Column of a beat within the eight-word block
	function automatic logic [COL_W-1:0] burst_col(input logic [COL_W-1:0] s,
		input logic [COL_W-1:0] b, input logic il);
		logic [COL_W-1:0] c;
		c = s ^ b; // RULE_03
		if (!il) begin
			c[NIB_B-1:0] = s[NIB_B-1:0] + b[NIB_B-1:0]; // RULE_02
		end
		return c;
	endfunction
	// One burst at a time, read or write
	assign cmd_ready_out = (rd_st_reg == RD_IDLE) && !wr_act_reg;
	assign rd_go = cmd_valid_in && cmd_ready_out && !cmd_in.wr;
	assign wr_go = cmd_valid_in && cmd_ready_out && cmd_in.wr;
	assign rd_issue = ((rd_st_reg == RD_WAIT) && (lat_cnt_reg == '0)) || (rd_st_reg == RD_BURST);
	// Chop tail and output-off leave drivers off
	assign rd_drv = rd_issue && !(chop_reg && (beat_reg >= CHOP_BEAT)) && !mr1_reg[QOFF_B]; // RULE_04
	// Same wait for chop and full bursts
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			rd_st_reg <= RD_IDLE;
			lat_cnt_reg <= '0;
			lat_reg <= '0;
			start_reg <= '0;
			beat_reg <= '0;
			ilv_reg <= 1'b0;
			chop_reg <= 1'b0;
		end else begin
			case (rd_st_reg)
				RD_IDLE: begin
					if (rd_go) begin
						rd_st_reg <= RD_WAIT;
						lat_cnt_reg <= cl_eff - LAT_LEAD; // RULE_07 RULE_15
						lat_reg <= cl_eff;
						start_reg <= cmd_in.col;
						ilv_reg <= mr0_reg[BT_B]; // RULE_01
						chop_reg <= chop_now;
						beat_reg <= '0;
					end
				end
				RD_WAIT: begin
					if (lat_cnt_reg == '0) begin
						rd_st_reg <= RD_BURST;
						beat_reg <= beat_reg + 1'b1;
					end else begin
						lat_cnt_reg <= lat_cnt_reg - 1'b1;
					end
				end
				RD_BURST: begin
					// All eight slots run, even when chopped
					beat_reg <= beat_reg + 1'b1;
					if (beat_reg == LAST_BEAT) begin
						rd_st_reg <= RD_IDLE; // RULE_04
					end
				end
				default: begin
					rd_st_reg <= RD_IDLE;
				end
			endcase
		end
	end
	// Array request stage
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			rd_req_reg <= 1'b0;
			rd_col_reg <= '0;
			iss_beat_reg <= '0;
		end else begin
			rd_req_reg <= rd_drv;
			iss_beat_reg <= beat_reg;
			if (rd_issue) begin
				rd_col_reg <= burst_col(start_reg, beat_reg, ilv_reg); // RULE_02 RULE_03
			end
		end
	end
	assign rd_req_out = rd_req_reg;
	assign rd_col_out = rd_col_reg;
	// Pin stage: data one clock after request
	logic [DQ_W-1:0] dq_reg;
	logic dq_oe_n_reg;
	logic dqs_reg;
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			dq_reg <= '0;
			dq_oe_n_reg <= 1'b1;
			dqs_reg <= 1'b0;
		end else begin
			dq_oe_n_reg <= !rd_req_reg; // RULE_04
			if (rd_req_reg) begin
				dq_reg <= array_rdata_in;
				dqs_reg <= !dqs_reg;
			end
		end
	end
	assign dq_out = dq_reg;
	assign dq_oe_n_out = dq_oe_n_reg;
	assign dqs_out = dqs_reg;
	// Age counter, saturating
	always_ff @(posedge clk_in) begin
		if (srst_in || rd_go) begin
			age_reg <= '0;
		end else if (age_reg != '1) begin
			age_reg <= age_reg + 1'b1;
		end
	end

	//*******************************
	// Write burst path
	//*******************************
	logic [COL_W-1:0] wbase_reg; // Block base column
	logic [COL_W:0] wlim_reg; // Beats kept
	logic [COL_W:0] wcnt_reg; // Beat slots seen
	logic w_keep;
	logic w_push;
	logic f_in_ready;
	mrb_wbeat_t w_word;
	assign w_keep = wcnt_reg < wlim_reg; // RULE_05
	assign w_push = wr_act_reg && wbeat_valid_in && w_keep;
	// Ignored slots never wait on the FIFO
	assign wbeat_ready_out = wr_act_reg && (!w_keep || f_in_ready);
	// Ascending from the block base, whatever the type
	assign w_word = '{col: wbase_reg + wcnt_reg[COL_W-1:0], dat: dq_in}; // RULE_06
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			wr_act_reg <= 1'b0;
			wbase_reg <= '0;
			wlim_reg <= '0;
			wcnt_reg <= '0;
		end else if (wr_go) begin
			wr_act_reg <= 1'b1;
			wcnt_reg <= '0;
			if (chop_now) begin
				wbase_reg <= cmd_in.col & CHOP_BEAT; // RULE_05
				wlim_reg <= BEATS_CHOP;
			end else begin
				wbase_reg <= '0; // RULE_06
				wlim_reg <= BEATS_FULL;
			end
		end else if (wbeat_valid_in && wbeat_ready_out) begin
			wcnt_reg <= wcnt_reg + 1'b1;
			if (wcnt_reg[COL_W-1:0] == LAST_BEAT) begin
				wr_act_reg <= 1'b0; // RULE_07
			end
		end
	end
	mrb_fifo #(
		.W($bits(mrb_wbeat_t)),
		.DEPTH(FIFO_DEPTH)
	) u_wfifo (
		.clk_in(clk_in),
		.srst_in(srst_in),
		.in_data_in(w_word),
		.in_valid_in(w_push),
		.in_ready_out(f_in_ready),
		.out_data_out(array_wr_out),
		.out_valid_out(array_wr_valid_out),
		.out_ready_in(array_wr_ready_in)
	);

	//*******************************
	// Assertions
	//*******************************
	default clocking @(posedge clk_in); endclocking
	default disable iff (srst_in);
	AST_ILV_ORDER: assert property (rd_req_out && ilv_reg |-> // RULE_03
		rd_col_out == (start_reg ^ iss_beat_reg)) else $error("interleave order");
	AST_SEQ_ORDER: assert property (rd_req_out && !ilv_reg |-> // RULE_02
		rd_col_out[1:0] == 2'(start_reg[1:0] + iss_beat_reg[1:0]) &&
		rd_col_out[2] == (start_reg[2] ^ iss_beat_reg[2])) else $error("sequential order");
	AST_CHOP_TRI: assert property (rd_st_reg == RD_BURST && chop_reg && beat_reg[2] |=> // RULE_04
		!rd_req_out ##1 dq_oe_n_out) else $error("chop tail driven");
	AST_CAS_LAT: assert property (rd_req_out && iss_beat_reg == '0 |=> // RULE_15
		age_reg == lat_reg && !dq_oe_n_out) else $error("read latency");
	AST_WR_CHOP: assert property (w_push && wlim_reg == BEATS_CHOP |-> // RULE_05
		w_word.col[1:0] == wcnt_reg[1:0] && wcnt_reg < 4'h4) else $error("chop write");
	AST_WR_FULL: assert property (w_push && wlim_reg == BEATS_FULL |-> // RULE_06
		w_word.col == wcnt_reg[2:0]) else $error("full write order");
	AST_DLL_RST: assert property (mr0_wr && mrs_in.val[8] |=> // RULE_08
		mr0_reg[8] && count_en_reg ##1 (!mr0_reg[8] || $past(mr0_wr))) else $error("dll reset");
	AST_DLL_OFF: assert property (!dll_en |-> // RULE_22
		read_latency_out == 5'h06 && !odt_allow_out && !dll_on_out) else $error("dll off mode");
	AST_SREF_EXIT: assert property ($fell(sref_s) && dll_en && !mr1_wr |=> // RULE_21
		count_en_reg && !dll_locked_out) else $error("sref exit reset");
	AST_PD_DLL: assert property (pdn_s && !sref_s && dll_en |-> // RULE_12
		dll_on_out == mr0_reg[12]) else $error("power-down dll");
	AST_WLVL: assert property (mr1_reg[7] |-> // RULE_19
		rtt_all_out != rtt_wr_only_out && rtt_all_out == mr1_reg[12]) else $error("leveling rtt");
	COV_CHOP_READ: cover property (rd_go && chop_now ##1 rd_st_reg == RD_WAIT);
	COV_ILV_READ: cover property (rd_req_out && ilv_reg && iss_beat_reg == 3'h7);
	COV_CHOP_WRITE: cover property (wr_go && chop_now && cmd_in.col[2]);
	COV_LOCKED: cover property ($rose(dll_locked_out));
endmodule

// file: dv/mrb_array_model.sv
// Purpose: Behavioural memory array beside the mode register block
// Assumes: One read column per cycle, write beats taken on ready
// Notes: Idle read data shows the inverse so a stale word never passes
module mrb_array_model import mrb_pkg::*; (
	input wire logic clk_in,
	input wire logic rd_req_in,
	input wire logic [COL_W-1:0] rd_col_in,
	output logic [DQ_W-1:0] rdata_out,
	input wire logic wr_valid_in,
	input wire mrb_wbeat_t wr_in,
	input wire logic stall_in,
	output logic wr_ready_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [DQ_W-1:0] mem [8]; // One word per burst column
	// Distinct words so a wrong column shows up
	initial for (int i = 0; i < 8; i++) mem[i] = DQ_W'(8'h3C + i * 8'h11);
	// Released data line: inverse, not last value
	assign rdata_out = rd_req_in ? mem[rd_col_in] : ~mem[rd_col_in];
	assign wr_ready_out = !stall_in; // Stalls come from the bench
	always @(posedge clk_in) if (wr_valid_in && wr_ready_out) mem[wr_in.col] <= wr_in.dat;
endmodule

// file: dv/sdram_mode_reg_burst_order_tb.sv
// Purpose: Self-checking bench for the mode register block
// Assumes: Inputs driven on the falling edge, seed fixed
// Notes: Expected orders and latencies are worked out here
module sdram_mode_reg_burst_order_tb import mrb_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_in, srst, mv, cv, cr, sref, pdn, rq, oe, dqs, wv, wr, av, ar, stall;
	logic don, lk, slow, odt, ra, rw;
	mrb_mrs_t ms;
	mrb_cmd_t cmd;
	mrb_wbeat_t aw;
	mrb_wbeat_t exp_q [$]; // Beats the array should see
	logic [2:0] rc;
	logic [7:0] rd, dq, wd;
	logic [4:0] rl, wrr;
	logic [12:0] m0;
	logic [17:0] m1;
	logic [31:0] rnd = 32'hE58B;
	int n_errors = 0, compares = 0, cyc = 0;
	mrb_mode_regs dut_u (.clk_in(clk_in), .srst_in(srst), .mrs_valid_in(mv), .mrs_in(ms),
		.cmd_valid_in(cv), .cmd_in(cmd), .cmd_ready_out(cr), .sref_in(sref), .pdn_in(pdn),
		.rd_req_out(rq), .rd_col_out(rc), .array_rdata_in(rd), .dq_out(dq), .dq_oe_n_out(oe),
		.dqs_out(dqs), .wbeat_valid_in(wv), .dq_in(wd), .wbeat_ready_out(wr),
		.array_wr_valid_out(av), .array_wr_out(aw), .array_wr_ready_in(ar),
		.read_latency_out(rl), .wr_recovery_out(wrr), .dll_on_out(don), .dll_locked_out(lk),
		.slow_pd_exit_out(slow), .odt_allow_out(odt), .rtt_all_out(ra), .rtt_wr_only_out(rw),
		.mode_zero_out(m0), .mode_one_out(m1));
	mrb_array_model arr_u (.clk_in(clk_in), .rd_req_in(rq), .rd_col_in(rc), .rdata_out(rd),
		.wr_valid_in(av), .wr_in(aw), .stall_in(stall), .wr_ready_out(ar));
	// ***************************
	// Helpers
	// ***************************
	// Wide enough for the packed reset image of both registers
	task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
		compares++;
		if (seen !== exp) begin
			n_errors++;
			$display("FAIL %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic step();
		rnd = {rnd[30:0], rnd[31] ^ rnd[21] ^ rnd[1] ^ rnd[0]}; // Shift register draw
	endtask
	// Register zero image, reserved bits kept zero
	function automatic logic [17:0] mr0(input logic [1:0] bl, input logic bt,
		input logic [3:0] cl, input logic [2:0] w, input logic pd, input logic rst);
		return {5'h00, pd, w, rst, 1'b0, cl[3:1], bt, cl[0], bl};
	endfunction
	task automatic mrs_wr(input logic [2:0] s, input logic [17:0] v);
		@(negedge clk_in);
		mv = 1;
		ms = '{sel: s, val: v};
		@(negedge clk_in);
		mv = 0;
	endtask
	// One read burst, latency five, checked slot by slot
	task automatic rdb(input logic bt, input logic [1:0] bl, input logic a12, input logic [2:0] s);
		logic ch;
		logic q;
		logic [2:0] c [8];
		ch = (bl == BL_FIX4) || (bl == BL_OTF && !a12);
		for (int b = 0; b < 8; b++) begin
			c[b] = bt ? s ^ b[2:0] : {s[2] ^ b[2], s[1:0] + b[1:0]};
		end
		mrs_wr(SEL_MR0, mr0(bl, bt, 4'h2, 3'h1, 1'b1, 1'b0));
		@(negedge clk_in);
		cv = 1;
		cmd = '{wr: 1'b0, a12: a12, col: s};
		@(negedge clk_in);
		cv = 0;
		chk("cmd_ready", cr, 0);
		chk("latency", rl, 5);
		repeat (4) @(negedge clk_in);
		q = dqs;
		for (int i = 0; i < 9; i++) begin
			if (i > 0) chk("dqs", dqs, q ^ !(ch && i > 4));
			q = dqs;
			if (i < 8) chk("rd_req", rq, !(ch && i > 3));
			if (i < 8 && !(ch && i > 3)) chk("rd_col", rc, c[i]);
			if (i == 0) chk("dq_oe_n", oe, 1);
			else chk("dq_oe_n", oe, ch && i > 4);
			if (i > 0 && !(ch && i > 4)) chk("dq", dq, arr_u.mem[c[i-1]]);
			@(negedge clk_in);
		end
		chk("dq_oe_n", oe, 1);
	endtask
	// One write burst, on-the-fly length
	task automatic wrb(input logic a12, input logic [2:0] s);
		@(negedge clk_in);
		cv = 1;
		cmd = '{wr: 1'b1, a12: a12, col: s};
		@(negedge clk_in);
		cv = 0;
		for (int k = 0; k < 8; k++) begin
			step();
			wv = 1;
			wd = rnd[7:0];
			while (wr !== 1'b1) @(negedge clk_in);
			if (k < 4 || a12) exp_q.push_back(mrb_wbeat_t'{a12 ? k[2:0] : {s[2], k[1:0]}, wd});
			@(negedge clk_in);
		end
		wv = 0;
	endtask
	// Array side sees every kept beat in order
	// Looked at mid-cycle, clear of the edge that pops the word and of bench drives
	always @(negedge clk_in) begin
		#2;
		if (av === 1'b1 && ar === 1'b1) begin
			chk("array_wr", aw, exp_q.size() ? exp_q.pop_front() : 11'h7FF);
		end
	end
	task automatic complete_run();
		$display("Comparisons %0d mismatches %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// ***************************
	// Clock, timeout, sequence
	// ***************************
	initial begin
		clk_in = 0;
		forever #10 clk_in = ~clk_in;
	end
	always @(posedge clk_in) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			complete_run();
		end
	end
	initial begin
		{srst, mv, cv, sref, pdn, wv, stall} = 7'h41;
		ms = '0;
		cmd = '0;
		wd = 8'h00;
		repeat (5) @(negedge clk_in);
		srst = 0;
		chk("reset", {m0, m1, oe, cr, lk}, 34'h6);
		mrs_wr(SEL_MR1, 18'h00000);
		chk("dll_on", don, 1);
		mrs_wr(SEL_MR0, mr0(2'h0, 0, 4'h2, 3'h1, 1, 1));
		chk("dll_rst_bit", m0[DLLRST_B], 1);
		@(negedge clk_in);
		chk("dll_rst_bit", m0[DLLRST_B], 0);
		repeat (505) @(negedge clk_in);
		chk("locked_early", lk, 0);
		repeat (10) @(negedge clk_in);
		chk("locked", lk, 1);
		sref = 1;
		repeat (4) @(negedge clk_in);
		chk("sref_dll", {don, odt}, 0);
		sref = 0;
		repeat (4) @(negedge clk_in);
		chk("sref_exit", {don, lk}, 2'h2);
		repeat (520) @(negedge clk_in);
		chk("relock", lk, 1);
		mrs_wr(SEL_MR1, 18'h00001);
		chk("dll_off", {don, odt, rl}, 7'h06);
		sref = 1;
		repeat (4) @(negedge clk_in);
		sref = 0;
		repeat (6) @(negedge clk_in);
		chk("stays_off", don, 0);
		mrs_wr(SEL_MR1, 18'h01080);
		chk("rtt", {ra, rw}, 2'h2);
		mrs_wr(SEL_MR1, 18'h00080);
		chk("rtt", {ra, rw}, 2'h1);
		mrs_wr(SEL_MR0, mr0(2'h0, 0, 4'h2, 3'h1, 0, 0));
		chk("mr1_kept", m1, 18'h00080);
		mrs_wr(SEL_MR1, 18'h00000);
		pdn = 1;
		repeat (4) @(negedge clk_in);
		chk("pd_slow", {don, slow}, 2'h1);
		mrs_wr(SEL_MR0, mr0(2'h0, 0, 4'h2, 3'h1, 1, 0));
		repeat (4) @(negedge clk_in);
		chk("pd_fast", {don, slow}, 2'h2);
		pdn = 0;
		for (int w = 1; w < 8; w++) begin
			mrs_wr(SEL_MR0, mr0(2'h0, 0, 4'h2, 3'(w), 1, 0));
			chk("wr_rec", wrr, w < 5 ? w + 4 : 2 * w);
		end
		for (int c = 0; c < 10; c++) begin
			mrs_wr(SEL_MR0, mr0(2'h0, 0, c < 7 ? {3'(c + 1), 1'b0} : {3'(c - 7), 1'b1}, 1, 1, 0));
			chk("cas_lat", rl, 5 + c);
		end
		rdb(1, 2'h0, 1, 3'h7);
		rdb(0, 2'h0, 1, 3'h1);
		rdb(0, BL_FIX4, 0, 3'h5);
		for (int i = 0; i < 20; i++) begin
			step();
			rdb(rnd[0], rnd[2] ? BL_OTF : (rnd[1] ? BL_FIX4 : 2'h0), rnd[3], rnd[6:4]);
		end
		mrs_wr(SEL_MR0, mr0(BL_OTF, 0, 4'h2, 3'h1, 1, 0));
		wrb(0, 3'h6);
		for (int i = 0; i < 6; i++) begin
			step();
			stall = rnd[9] & rnd[5];
			wrb(rnd[0], rnd[3:1]);
		end
		// Empty the FIFO first so two full bursts fill it exactly
		stall = 0;
		repeat (20) @(negedge clk_in);
		stall = 1;
		wrb(1, 3'h3);
		wrb(1, 3'h0);
		fork
			wrb(1, 3'h5);
			begin
				repeat (30) @(negedge clk_in);
				chk("fifo_full", {wr, av}, 2'h1);
				stall = 0;
			end
		join
		repeat (30) @(negedge clk_in);
		chk("drained", {av, 31'(exp_q.size())}, 0);
		complete_run();
	end
endmodule
